// File: vspl_consts.svh
// constants for the setpoint and limit register bank
`ifndef VSPL_CONSTS_SVH
`define VSPL_CONSTS_SVH
`define VSPL_CMD_TRIM      8'h22
`define VSPL_CMD_CEIL      8'h24
`define VSPL_CMD_MHIGH     8'h25
`define VSPL_CMD_MLOW      8'h26
`define VSPL_CMD_SLEW      8'h27
`define VSPL_RST_TRIM      16'h0000
`define VSPL_RST_CEIL      16'h08FC
`define VSPL_RST_MHIGH     16'h0640
`define VSPL_RST_MLOW      16'h00FA
`define VSPL_RST_SLEW      16'h0064
`define VSPL_RST_NOMINAL   16'h0384
`define VSPL_WP_NONE       8'h00
`define VSPL_WP_TRIM_OK    8'h20
`define VSPL_WP_LOCKED     8'h40
`define VSPL_CEIL_MAX_MV   16'h0CE4
`define VSPL_TRIM_MAX_MV   16'h00FA
`define VSPL_SLEW_MIN      16'h0001
`define VSPL_SLEW_MAX      16'h03E8
`define VSPL_SRC_NOMINAL   2'h0
`define VSPL_SRC_MLOW      2'h1
`define VSPL_SRC_MHIGH     2'h2
`define VSPL_SRC_AVS       2'h3
`endif

// File: vspl_pkg.sv
// types shared by the setpoint and limit register bank
package vspl_pkg;
	typedef logic [15:0] vspl_word_t;
	typedef enum logic [1:0] {
		VSPL_SEL_NOMINAL,
		VSPL_SEL_MLOW,
		VSPL_SEL_MHIGH,
		VSPL_SEL_AVS
	} vspl_src_t;
endpackage

// File: vspl_target_calc.sv
// per-output target former: setpoint plus trim, clamped to ceiling
`timescale 1ns/1ps
module vspl_target_calc
	import vspl_pkg::*;
(
	input  wire logic [15:0] setpoint,   // selected setpoint, mV
	input  wire logic [15:0] trim,       // signed trim, mV
	input  wire logic [15:0] ceiling,    // ceiling, mV
	output logic      [15:0] target      // clamped target, mV
);
	logic signed [17:0] sum;             // widened sum, never wraps
	logic signed [17:0] ceil_s;          // ceiling widened signed

	// sum and clamp; negative results floor at zero
	always_comb begin
		sum    = $signed({2'b00, setpoint}) + $signed({{2{trim[15]}}, trim});
		ceil_s = $signed({2'b00, ceiling});
		if (sum > ceil_s) begin
			target = ceiling;
		end else if (sum < 18'sd0) begin
			target = 16'h0000;
		end else begin
			target = sum[15:0];
		end
	end
endmodule

// File: vspl_regs.sv
// paged setpoint, ceiling, margin and slew registers for two outputs
// Summary of operation
// - trim is signed mV offset, +-250 mV
// - target never exceeds the ceiling
// - ceiling unsigned mV, host keeps 0-3300
// - margin-high source uses upper margin value
// - margin-low source uses lower margin value
// - host keeps margins between floor and ceiling
// - slew counts 100 uV/us steps, range not enforced
// - slew change waits for commit command
// - two-byte registers held per page
// - trim writable at level 20h, not 40h
`timescale 1ns/1ps
`include "vspl_consts.svh"
module vspl_regs
	import vspl_pkg::*;
#(
	parameter int PAGES = 2              // number of output pages
)
(
	input  wire logic        clk_sys,         // 20 MHz system clock
	input  wire logic        nrst,            // sync reset, active low
	input  wire logic        wr_en,           // write strobe, one cycle
	input  wire logic        rd_en,           // read strobe, one cycle
	input  wire logic [7:0]  cmd_code,        // command code of access
	input  wire logic [15:0] wr_data,         // write word, low byte first
	input  wire logic        page_sel,        // selected output page
	input  wire logic [7:0]  write_protect,   // write-protect level
	input  wire logic        commit_pending_settings, // commit pulse
	input  wire logic [1:0]  src_sel0,        // target source, page 0
	input  wire logic [1:0]  src_sel1,        // target source, page 1
	input  wire logic [15:0] nominal0,        // nominal setpoint page 0
	input  wire logic [15:0] nominal1,        // nominal setpoint page 1
	input  wire logic [15:0] avs0,            // avs target page 0
	input  wire logic [15:0] avs1,            // avs target page 1
	output logic      [15:0] rd_data,         // read word, registered
	output logic             rd_valid,        // read answer pulse
	output logic             wr_reject,       // write refused pulse
	output logic             cmd_unknown,     // unmapped code pulse
	output logic      [15:0] target0,         // clamped target page 0
	output logic      [15:0] target1,         // clamped target page 1
	output logic      [15:0] slew_active0,    // applied slew page 0
	output logic      [15:0] slew_active1     // applied slew page 1
);
	// whole state of the bank in one struct
	typedef struct packed {
		logic [1:0][15:0] trim;      // per-page trim
		logic [1:0][15:0] ceil;      // per-page ceiling
		logic [1:0][15:0] mhigh;     // per-page upper margin
		logic [1:0][15:0] mlow;      // per-page lower margin
		logic [1:0][15:0] slew_wr;   // written, not yet applied
		logic [1:0][15:0] slew_act;  // applied slew
		logic [15:0]      rdat;      // read answer data
		logic             rval;      // read answer valid
		logic             rej;       // write refused
		logic             unk;       // unknown code
	} vspl_state_t;

	vspl_state_t st;                 // registered state
	vspl_state_t next_st;            // next state
	logic [1:0][15:0] setp;          // selected setpoint per page
	logic [1:0][1:0]  srcs;          // source selects per page
	logic [1:0][15:0] noms;          // nominal values per page
	logic [1:0][15:0] avss;          // avs values per page
	logic             pg;            // page index
	logic             known;         // code is one of ours
	logic             wr_ok;         // protection allows write

	assign srcs = {src_sel1, src_sel0};
	assign noms = {nominal1, nominal0};
	assign avss = {avs1, avs0};
	assign pg   = page_sel;

	// source selection per page
	always_comb begin
		for (int p = 0; p < PAGES; p++) begin
			unique case (srcs[p])
				`VSPL_SRC_MHIGH:  setp[p] = st.mhigh[p];
				`VSPL_SRC_MLOW:   setp[p] = st.mlow[p];
				`VSPL_SRC_AVS:    setp[p] = avss[p];
				default:          setp[p] = noms[p];
			endcase
		end
	end

	// decode of command code and protection level
	always_comb begin
		known = (cmd_code == `VSPL_CMD_TRIM) ||
			(cmd_code == `VSPL_CMD_CEIL) ||
			(cmd_code == `VSPL_CMD_MHIGH) ||
			(cmd_code == `VSPL_CMD_MLOW) ||
			(cmd_code == `VSPL_CMD_SLEW);
		if (write_protect == `VSPL_WP_NONE) begin
			wr_ok = 1'b1;
		end else if (write_protect == `VSPL_WP_TRIM_OK) begin
			wr_ok = (cmd_code == `VSPL_CMD_TRIM);
		end else begin
			// 40h and invalid levels lock everything here
			wr_ok = 1'b0;
		end
	end

	// next-state for writes, reads and commit
	always_comb begin
		next_st      = st;
		next_st.rval = 1'b0;
		next_st.rej  = 1'b0;
		next_st.unk  = 1'b0;
		if (commit_pending_settings) begin
			next_st.slew_act = st.slew_wr;
		end
		// write lands on selected page only
		if (wr_en) begin
			if (!known) begin
				next_st.unk = 1'b1;
			end else if (!wr_ok) begin
				next_st.rej = 1'b1;
			end else begin
				unique case (cmd_code)
					`VSPL_CMD_TRIM:  next_st.trim[pg]    = wr_data;
					`VSPL_CMD_CEIL:  next_st.ceil[pg]    = wr_data;
					`VSPL_CMD_MHIGH: next_st.mhigh[pg]   = wr_data;
					`VSPL_CMD_MLOW:  next_st.mlow[pg]    = wr_data;
					`VSPL_CMD_SLEW:  next_st.slew_wr[pg] = wr_data;
					default:         next_st.unk         = 1'b1;
				endcase
			end
		end
		// read returns the selected page's value
		if (rd_en) begin
			next_st.rval = 1'b1;
			unique case (cmd_code)
				`VSPL_CMD_TRIM:  next_st.rdat = st.trim[pg];
				`VSPL_CMD_CEIL:  next_st.rdat = st.ceil[pg];
				`VSPL_CMD_MHIGH: next_st.rdat = st.mhigh[pg];
				`VSPL_CMD_MLOW:  next_st.rdat = st.mlow[pg];
				// pending value reads back, as software wrote it
				`VSPL_CMD_SLEW:  next_st.rdat = st.slew_wr[pg];
				default: begin
					next_st.rdat = 16'h0000;
					next_st.unk  = 1'b1;
				end
			endcase
		end
	end

	// state register with synchronous reset
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			for (int p = 0; p < 2; p++) begin
				st.trim[p]     <= `VSPL_RST_TRIM;
				st.ceil[p]     <= `VSPL_RST_CEIL;
				st.mhigh[p]    <= `VSPL_RST_MHIGH;
				st.mlow[p]     <= `VSPL_RST_MLOW;
				st.slew_wr[p]  <= `VSPL_RST_SLEW;
				st.slew_act[p] <= `VSPL_RST_SLEW;
			end
			st.rdat <= 16'h0000;
			st.rval <= 1'b0;
			st.rej  <= 1'b0;
			st.unk  <= 1'b0;
		end else begin
			st <= next_st;
		end
	end

	// one target former per page
	vspl_target_calc u_calc0 (
		.setpoint (setp[0]),
		.trim     (st.trim[0]),
		.ceiling  (st.ceil[0]),
		.target   (target0)
	);
	vspl_target_calc u_calc1 (
		.setpoint (setp[1]),
		.trim     (st.trim[1]),
		.ceiling  (st.ceil[1]),
		.target   (target1)
	);

	assign rd_data      = st.rdat;
	assign rd_valid     = st.rval;
	assign wr_reject    = st.rej;
	assign cmd_unknown  = st.unk;
	assign slew_active0 = st.slew_act[0];
	assign slew_active1 = st.slew_act[1];
endmodule

// File: vspl_sva.sv
// concurrent checks on the setpoint register bank ports
`timescale 1ns/1ps
`include "vspl_consts.svh"
module vspl_sva
	import vspl_pkg::*;
(
	input wire logic        clk_sys,        // clock
	input wire logic        nrst,           // reset
	input wire logic        wr_en,          // write
	input wire logic        rd_en,          // read
	input wire logic [7:0]  cmd_code,       // code
	input wire logic [15:0] wr_data,        // data
	input wire logic        page_sel,       // page
	input wire logic [7:0]  write_protect,  // protect
	input wire logic        commit_pending_settings, // commit
	input wire logic        rd_valid,       // answer
	input wire logic        wr_reject,      // refused
	input wire logic        cmd_unknown,    // unmapped
	input wire logic [15:0] target0,        // target
	input wire logic [15:0] slew_active0    // slew
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	logic [15:0] ceil0;  // shadow ceiling, page 0
	logic [15:0] slew0;  // shadow pending slew
	wire known = cmd_code inside {8'h22, 8'h24, 8'h25, 8'h26, 8'h27};
	// shadow only tracks unprotected page-0 writes
	always_ff @(posedge clk_sys) begin
		if (!nrst) begin
			ceil0 <= `VSPL_RST_CEIL;
			slew0 <= `VSPL_RST_SLEW;
		end else if (wr_en && !page_sel && write_protect == 8'h00) begin
			if (cmd_code == 8'h24) ceil0 <= wr_data;
			if (cmd_code == 8'h27) slew0 <= wr_data;
		end
	end
	rd_answer_a: assert property (rd_en |=> rd_valid)
		else $error("read not answered");
	rd_quiet_a: assert property (!rd_en |=> !rd_valid)
		else $error("stray read answer");
	lock_refuse_a: assert property (wr_en && known && write_protect == 8'h40 |=> wr_reject)
		else $error("locked write taken");
	trim_accept_a: assert property (wr_en && cmd_code == 8'h22 && write_protect == 8'h20 |=> !wr_reject)
		else $error("trim write refused");
	ceil_bound_a: assert property (target0 <= ceil0)
		else $error("target above ceiling");
	slew_hold_a: assert property (!commit_pending_settings |=> $stable(slew_active0))
		else $error("slew moved without commit");
	slew_apply_a: assert property (commit_pending_settings |=> slew_active0 == $past(slew0))
		else $error("commit did not apply slew");
	code_flag_a: assert property ((wr_en || rd_en) && !known |=> cmd_unknown)
		else $error("unmapped code not flagged");
endmodule
bind vspl_regs vspl_sva chk (.clk_sys, .nrst, .wr_en, .rd_en, .cmd_code,
	.wr_data, .page_sel, .write_protect, .commit_pending_settings,
	.rd_valid, .wr_reject, .cmd_unknown, .target0, .slew_active0);

// File: vspl_host.sv
// host model issuing paged register accesses
`timescale 1ns/1ps
module vspl_host (
	input  wire logic        clk_sys,   // clock
	output logic             wr_en,     // write
	output logic             rd_en,     // read
	output logic      [7:0]  cmd_code,  // code
	output logic      [15:0] wr_data,   // data
	output logic             page_sel,  // page
	input  wire logic [15:0] rd_data,   // read word
	input  wire logic        rd_valid,  // answer
	input  wire logic        wr_reject  // refused
);
	initial begin
		{wr_en, rd_en, page_sel, cmd_code, wr_data} = '0;
	end
	// page set with code; values kept legal by callers
	task automatic wr(input logic p, input logic [7:0] c,
		input logic [15:0] d, output logic rej);
		@(negedge clk_sys);
		{page_sel, cmd_code, wr_data, wr_en} = {p, c, d, 1'b1};
		@(negedge clk_sys);
		rej = wr_reject;
		wr_en = 1'b0;
		wr_data = ~d;  // released data is not left standing
	endtask
	task automatic rd(input logic p, input logic [7:0] c,
		output logic [15:0] d, output logic ok);
		@(negedge clk_sys);
		{page_sel, cmd_code, rd_en} = {p, c, 1'b1};
		@(negedge clk_sys);
		d = rd_data;
		ok = rd_valid;
		rd_en = 1'b0;
	endtask
endmodule

// File: vspl_regs_tb.sv
// self-checking bench for the setpoint register bank
`timescale 1ns/1ps
module vspl_regs_tb import vspl_pkg::*;;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic commit_pending_settings = 1'b0;
	logic [7:0] write_protect = 8'h00;
	logic [1:0] src_sel0 = VSPL_SEL_NOMINAL;
	logic wr_en, rd_en, page_sel, rd_valid, wr_reject, ok, rej, cmd_unknown;
	logic [7:0] cmd_code;
	logic [15:0] wr_data, rd_data, target0, target1, got;
	logic [15:0] slew_active0, slew_active1;
	int err_count = 0;
	int checks_done = 0;
	always #25 clk_sys = ~clk_sys;
	vspl_host h (.clk_sys, .wr_en, .rd_en, .cmd_code, .wr_data,
		.page_sel, .rd_data, .rd_valid, .wr_reject);
	vspl_regs dut (.clk_sys, .nrst, .wr_en, .rd_en, .cmd_code, .wr_data,
		.page_sel, .write_protect, .commit_pending_settings, .src_sel0,
		.src_sel1(2'h0), .nominal0(16'h0384), .nominal1(16'h0384),
		.avs0(16'h0300), .avs1(16'h0300), .rd_data, .rd_valid, .wr_reject,
		.cmd_unknown, .target0, .target1, .slew_active0,
		.slew_active1);
	task automatic check(input logic [15:0] seen, input logic [15:0] want);
		checks_done++;
		if (seen !== want) begin
			err_count++;
			$display("unexpected at %0t: %h not %h", $time, seen, want);
		end
	endtask
	task automatic t_reset();
		logic [7:0] c [5] = '{8'h22, 8'h24, 8'h25, 8'h26, 8'h27};
		logic [15:0] v [5] = '{16'h0, 16'h08FC, 16'h0640, 16'h00FA, 16'h0064};
		for (int i = 0; i < 5; i++) begin
			h.rd(1'b1, c[i], got, ok);
			check(got, v[i]);
			check({15'h0, ok}, 16'h0001);
		end
		check(target0, 16'h0384);
		check(target1, 16'h0384);
		$display("reset test done");
	endtask
	task automatic t_margin();
		src_sel0 = VSPL_SEL_MHIGH;
		@(negedge clk_sys);
		check(target0, 16'h0640);
		src_sel0 = VSPL_SEL_MLOW;
		h.wr(1'b0, 8'h22, 16'hFF06, rej);
		check(target0, 16'h0000);
		src_sel0 = VSPL_SEL_MHIGH;
		h.wr(1'b0, 8'h22, 16'h00FA, rej);
		h.wr(1'b0, 8'h24, 16'h0700, rej);
		check(target0, 16'h0700);
		h.wr(1'b0, 8'h22, 16'hFF9C, rej);
		check(target0, 16'h05DC);
		$display("margin test done");
	endtask
	task automatic t_slew();
		h.wr(1'b1, 8'h27, 16'h00C8, rej);
		check(slew_active1, 16'h0064);
		h.rd(1'b1, 8'h24, got, ok);
		check(got, 16'h08FC);
		commit_pending_settings = 1'b1;
		@(negedge clk_sys);
		commit_pending_settings = 1'b0;
		check(slew_active1, 16'h00C8);
		check(slew_active0, 16'h0064);
		$display("slew test done");
	endtask
	task automatic t_protect();
		write_protect = 8'h20;
		h.wr(1'b0, 8'h22, 16'h0005, rej);
		check({15'h0, rej}, 16'h0000);
		h.wr(1'b0, 8'h24, 16'h0100, rej);
		check({15'h0, rej}, 16'h0001);
		write_protect = 8'h40;
		h.wr(1'b0, 8'h22, 16'h0009, rej);
		check({15'h0, rej}, 16'h0001);
		h.rd(1'b0, 8'h22, got, ok);
		check(got, 16'h0005);
		h.rd(1'b0, 8'h23, got, ok);
		check(got, 16'h0000);
		check({15'h0, cmd_unknown}, 16'h0001);
		write_protect = 8'h00;
		$display("protect test done");
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		#100000;
		err_count++;
		close_out();
	end
	initial begin
		repeat (3) @(negedge clk_sys);
		nrst = 1'b1;
		t_reset();
		t_margin();
		t_slew();
		t_protect();
		close_out();
	end
endmodule
